// *** verilog/timer_slave_pkg.sv ***
/*
  Package for the timer slave/master/single-pulse block: register map,
  field positions, mode codes, state enum and trigger input carrier struct.
  Assumes a 32-bit classic Wishbone slave with word-aligned registers.
*/
`default_nettype none
package timer_slave_pkg;
  // Byte offsets
  localparam logic [7:0] OFS_CTL0 = 8'h00;
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_SMCFG = 8'h08;
  localparam logic [7:0] OFS_DMACFG = 8'h48;
  localparam logic [7:0] OFS_DMAWIN = 8'h4C;
  localparam logic [7:0] OFS_CNT = 8'h24;
  localparam logic [7:0] OFS_CAR = 8'h2C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_CHCTL = 8'h18;
  localparam logic [7:0] OFS_CHCV = 8'h34;
  localparam logic [31:0] RST_VAL = 32'h00000000;
  // Control 0 fields
  localparam int CEN_POS = 0;
  localparam int SPM_POS = 3;
  localparam int SAMPLE_CLOCK_DIVIDER_LSB = 8;
  // Control 1 fields
  localparam int MMC_LSB = 4;
  // Slave config fields
  localparam int SMC_LSB = 0;
  localparam int TRIGGER_SOURCE_SELECT_LSB = 4;
  localparam int MSM_POS = 7;
  localparam int EXT_TRIGGER_FILTER_CFG_LSB = 8;
  localparam int EXT_TRIGGER_DIVIDER_LSB = 12;
  localparam int ETP_POS = 15;
  localparam int TRGS3_POS = 31;
  // DMA config fields
  localparam int DMA_START_ADDRESS_LSB = 0;
  localparam int DMA_TRANSFER_COUNT_LSB = 8;
  // Channel control fields
  localparam int CHMS_LSB = 0;
  localparam int CPWM_POS = 3;
  localparam int CHCAPFLT_LSB = 4;
  // Status bits
  localparam int TRIGGER_INTERRUPT_FLAG_POS = 6;
  localparam int UPIF_POS = 0;
  // Mode codes
  localparam logic [2:0] SMC_RESTART = 3'h4;
  localparam logic [2:0] SMC_PAUSE = 3'h5;
  localparam logic [2:0] SMC_EVENT = 3'h6;
  localparam logic [2:0] SMC_EXTCLK0 = 3'h7;
  localparam logic [3:0] TRG_INTERNAL_TRIGGER_LINE_0 = 4'h0;
  localparam logic [3:0] TRG_INTERNAL_TRIGGER_LINE_1 = 4'h1;
  localparam logic [3:0] TRG_CI0 = 4'h4;
  localparam logic [3:0] TRG_ETI = 4'h7;
  localparam logic [2:0] MMC_ENABLE = 3'h1;
  localparam logic [2:0] MMC_UPDATE = 3'h2;
  localparam logic [2:0] CHMS_OUTPUT = 3'h0;
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_2 = 2'h1;
  localparam logic [1:0] DIV_4 = 2'h2;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    DMA_IDLE = 2'b00,
    DMA_REQ = 2'b01,
    DMA_WAIT = 2'b10
  } dma_state_e;

  typedef struct packed {
    logic internal_trigger_line_0;
    logic internal_trigger_line_1;
    logic chan0;
    logic extTrig;
  } trig_in_s;
endpackage
`default_nettype wire

// *** verilog/timer_slave_sync.sv ***
/*
  Timer slave-mode, master-output, single-pulse, DMA burst and debug hold.
  Assumes a classic Wishbone master, asynchronous trigger pins, and a DMA
  controller that accesses the window register once per request.
*/
// Behaviour
// - Slave mode field codes 100 restart, 101 pause, 110 event.
// - Trigger select 0000 picks internal line 0, 0001 internal line 1.
// - Trigger select 100 picks the filtered channel 0 edge.
// - Restart mode clears and restarts counter on trigger rising edge.
// - Pause mode holds the counter while trigger low, resumes afterwards.
// - Internal trigger lines reach slave logic unfiltered and unprescaled.
// - Channel trigger uses the capture filter setting, no prescaler.
// - External trigger filtered by its filter field, divided by prescaler.
// - Single pulse mode clears and stops the counter at next update.
// - Single pulse starts by enable bit or trigger, enable held until update.
// - Software clearing enable stops the counter and keeps its count.
// - Trigger edge in single pulse forces reference to post-match state.
// - Single pulse also works with composite PWM and output channel mode.
// - Master mode 010 drives update event onto trigger output.
// - Master mode 001 drives counter enable onto trigger output.
// - Slave mode 111 counts selected trigger edges as external clock.
// - Event mode trigger sets enable; counter then runs until disabled.
// - Master/slave bit delays start to align output; trigger sets flag.
// - DMA window accesses go to register chosen by start address field.
// - Each DMA event issues count+1 requests at start plus 4, 8, 12.
// - Counter freezes in debug halt when debug hold bit is set.
// - Clock division field selects sample clock /1, /2, /4; 11 reserved.
`default_nettype none
module timer_slave_sync
  import timer_slave_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire trig_in_s trigPins,
  input wire logic debugHalt,
  input wire logic debugHoldBit,
  input wire logic dmaEventReq,
  output logic dmaReq,
  output logic triggerOutputLine,
  output logic preOutputReference
);
  // Counter width must fit the 32-bit register words
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W out of range");
  end

  logic rstMeta, rstSync;
  logic [31:0] ctl0_q, ctl0_d, ctl1_q, ctl1_d, smcfg_q, smcfg_d;
  logic [31:0] dmacfg_q, dmacfg_d, chctl_q, chctl_d, stat_q, stat_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, car_q, car_d, cv_q, cv_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [3:0] syncA_q, syncB_q, prev_q;
  logic [3:0] filt_q, filt_d;
  logic [3:0] fcnt0_q, fcnt0_d, fcnt3_q, fcnt3_d;
  logic [1:0] divCnt_q, divCnt_d;
  logic [2:0] psc_q, psc_d;
  logic pscOut_q, pscOut_d;
  logic trigSel_q, sampleEn;
  logic alignStart_q, alignStart_d;
  logic ref_q, ref_d;
  logic trigger_output_line_q, trigger_output_line_d;
  dma_state_e dmaSt_q, dmaSt_d;
  logic [4:0] dmaIdx_q, dmaIdx_d;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Two-flop synchronisers; only stage B is read
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      syncA_q <= 4'h0;
      syncB_q <= 4'h0;
    end else begin
      syncA_q <= {trigPins.extTrig, trigPins.chan0, trigPins.internal_trigger_line_1, trigPins.internal_trigger_line_0};
      syncB_q <= syncA_q;
    end
  end

  // Sample clock enable from the division field
  always_comb begin
    divCnt_d = divCnt_q + 2'h1;
    case (ctl0_q[SAMPLE_CLOCK_DIVIDER_LSB+:2])
      DIV_1: sampleEn = 1'b1;
      DIV_2: sampleEn = divCnt_q[0];
      DIV_4: sampleEn = (divCnt_q == 2'h3);
      default: sampleEn = 1'b1; // Reserved code behaves as undivided
    endcase
  end

  // Filter run length: N consecutive equal samples (0 means bypass)
  function automatic logic [3:0] filtLen(input logic [3:0] cfg);
    filtLen = cfg;
  endfunction

  // Digital filters on channel 0 and external trigger; internal lines pass
  logic extPol;
  assign extPol = syncB_q[3] ^ smcfg_q[ETP_POS];
  always_comb begin
    filt_d = filt_q;
    fcnt0_d = fcnt0_q;
    fcnt3_d = fcnt3_q;
    filt_d[1:0] = syncB_q[1:0];
    if (filtLen(chctl_q[CHCAPFLT_LSB+:4]) == 4'h0) begin
      filt_d[2] = syncB_q[2];
    end else if (sampleEn) begin
      if (syncB_q[2] == filt_q[2]) begin
        fcnt0_d = 4'h0;
      end else if (fcnt0_q + 4'h1 >= filtLen(chctl_q[CHCAPFLT_LSB+:4])) begin
        filt_d[2] = syncB_q[2];
        fcnt0_d = 4'h0;
      end else begin
        fcnt0_d = fcnt0_q + 4'h1;
      end
    end
    if (filtLen(smcfg_q[EXT_TRIGGER_FILTER_CFG_LSB+:4]) == 4'h0) begin
      filt_d[3] = extPol;
    end else if (sampleEn) begin
      if (extPol == filt_q[3]) begin
        fcnt3_d = 4'h0;
      end else if (fcnt3_q + 4'h1 >= filtLen(smcfg_q[EXT_TRIGGER_FILTER_CFG_LSB+:4])) begin
        filt_d[3] = extPol;
        fcnt3_d = 4'h0;
      end else begin
        fcnt3_d = fcnt3_q + 4'h1;
      end
    end
  end

  // External trigger prescaler pulses output once every 2^field rising edges; field 0 passes the level
  logic extRise;
  assign extRise = filt_q[3] & ~prev_q[3];
  always_comb begin
    psc_d = psc_q;
    pscOut_d = pscOut_q;
    if (smcfg_q[EXT_TRIGGER_DIVIDER_LSB+:2] == 2'h0) begin
      pscOut_d = filt_q[3];
    end else if (extRise) begin
      psc_d = psc_q + 3'h1;
      if ((psc_q & ((3'h1 << smcfg_q[EXT_TRIGGER_DIVIDER_LSB+:2]) - 3'h1)) ==
          ((3'h1 << smcfg_q[EXT_TRIGGER_DIVIDER_LSB+:2]) - 3'h1)) begin
        pscOut_d = 1'b1;
      end else begin
        pscOut_d = 1'b0;
      end
    end else begin
      pscOut_d = 1'b0;
    end
  end

  // Trigger selection and rising edge detect
  logic [3:0] trgSelField;
  logic trigLevel, trigRise;
  assign trgSelField = {smcfg_q[TRGS3_POS], smcfg_q[TRIGGER_SOURCE_SELECT_LSB+:3]};
  always_comb begin
    case (trgSelField)
      TRG_INTERNAL_TRIGGER_LINE_0: trigLevel = filt_q[0];
      TRG_INTERNAL_TRIGGER_LINE_1: trigLevel = filt_q[1];
      TRG_CI0: trigLevel = filt_q[2];
      TRG_ETI: trigLevel = pscOut_q;
      default: trigLevel = 1'b0;
    endcase
  end
  assign trigRise = trigLevel & ~trigSel_q;

  // Counter, enable, single pulse and master output
  logic [2:0] slave_mode_select;
  logic frozen, running, overflow, cenSet, trigStart;
  assign slave_mode_select = smcfg_q[SMC_LSB+:3];
  assign frozen = debugHalt & debugHoldBit;
  assign trigStart = trigRise & (slave_mode_select == SMC_EVENT || ctl0_q[SPM_POS]);
  // Pause keeps counting only while the trigger is high
  assign running = ctl0_q[CEN_POS] & ~frozen &
                   ~(slave_mode_select == SMC_PAUSE && !trigLevel);
  assign overflow = running & (slave_mode_select != SMC_EXTCLK0 || trigRise) & (cnt_q >= car_q);
  logic busWrite, winAccess;
  logic [7:0] dmaTarget, effAdr;
  assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;

  always_comb begin
    cnt_d = cnt_q;
    ctl0_d = ctl0_q;
    stat_d = stat_q;
    ref_d = ref_q;
    trigger_output_line_d = 1'b0;
    alignStart_d = 1'b0;
    cenSet = 1'b0;
    // Control and status writes first; hardware sets and counting below win over them
    if (busWrite && effAdr == OFS_CTL0 && wb_sel_i[0]) begin
      ctl0_d[7:0] = wb_dat_i[7:0];
    end
    if (busWrite && effAdr == OFS_CTL0 && wb_sel_i[1]) begin
      ctl0_d[15:8] = wb_dat_i[15:8] & 8'h03;
    end
    if (busWrite && effAdr == OFS_STAT && wb_sel_i[0]) begin
      stat_d[7:0] = stat_q[7:0] & wb_dat_i[7:0];
    end
    // Master/slave alignment delays own start by one cycle to match peers
    if (trigStart && !ctl0_q[CEN_POS]) begin
      if (smcfg_q[MSM_POS]) begin
        alignStart_d = 1'b1;
      end else begin
        cenSet = 1'b1;
      end
    end
    if (alignStart_q) begin
      cenSet = 1'b1;
    end
    if (cenSet) begin
      ctl0_d[CEN_POS] = 1'b1;
    end
    if (trigRise && slave_mode_select >= SMC_RESTART) begin
      stat_d[TRIGGER_INTERRUPT_FLAG_POS] = 1'b1;
    end
    if (slave_mode_select == SMC_RESTART && trigRise) begin
      cnt_d = '0;
    end else if (overflow) begin
      cnt_d = '0;
      stat_d[UPIF_POS] = 1'b1;
      if (ctl0_q[SPM_POS]) begin
        ctl0_d[CEN_POS] = 1'b0;
      end
    end else if (running && (slave_mode_select != SMC_EXTCLK0 || trigRise)) begin
      cnt_d = cnt_q + 1'b1;
    end
    // Reference output in single pulse; output mode or composite PWM
    if (ctl0_q[SPM_POS] && chctl_q[CHMS_LSB+:3] == CHMS_OUTPUT) begin
      if (trigRise) begin
        ref_d = 1'b1;
      end else if (running && cnt_q + 1'b1 == cv_q) begin
        ref_d = 1'b1;
      end else if (overflow) begin
        ref_d = chctl_q[CPWM_POS];
      end
    end else begin
      ref_d = running & (cnt_q >= cv_q);
    end
    case (ctl1_q[MMC_LSB+:3])
      MMC_UPDATE: trigger_output_line_d = overflow;
      MMC_ENABLE: trigger_output_line_d = ctl0_d[CEN_POS];
      default: trigger_output_line_d = 1'b0;
    endcase
    if (busWrite && effAdr == OFS_CNT) begin
      cnt_d = wb_dat_i[CNT_W-1:0];
    end
  end

  // DMA burst sequencing through the window register
  assign dmaTarget = 8'(({3'h0, dmacfg_q[DMA_START_ADDRESS_LSB+:5]} + {3'h0, dmaIdx_q}) << 2);
  assign effAdr = (wb_adr_i == OFS_DMAWIN) ? dmaTarget : wb_adr_i;
  assign winAccess = wb_cyc_i & wb_stb_i & ~ack_q & (wb_adr_i == OFS_DMAWIN);
  always_comb begin
    dmaSt_d = dmaSt_q;
    dmaIdx_d = dmaIdx_q;
    case (dmaSt_q)
      DMA_IDLE: begin
        dmaIdx_d = 5'h0;
        if (dmaEventReq) begin
          dmaSt_d = DMA_REQ;
        end
      end
      DMA_REQ: begin
        if (winAccess) begin
          dmaSt_d = DMA_WAIT;
        end
      end
      DMA_WAIT: begin
        if (dmaIdx_q == dmacfg_q[DMA_TRANSFER_COUNT_LSB+:5]) begin
          dmaSt_d = DMA_IDLE;
        end else begin
          dmaIdx_d = dmaIdx_q + 5'h1;
          dmaSt_d = DMA_REQ;
        end
      end
      default: dmaSt_d = DMA_IDLE;
    endcase
  end
  assign dmaReq = (dmaSt_q == DMA_REQ);

  // Other registers, answer and read mux
  always_comb begin
    ctl1_d = ctl1_q;
    smcfg_d = smcfg_q;
    dmacfg_d = dmacfg_q;
    chctl_d = chctl_q;
    car_d = car_q;
    cv_d = cv_q;
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d = rdat_q;
    if (busWrite) begin
      case (effAdr)
        OFS_CTL1: ctl1_d = wb_dat_i & 32'h00000070;
        OFS_SMCFG: smcfg_d = wb_dat_i & 32'h8000FFF7;
        OFS_DMACFG: dmacfg_d = wb_dat_i & 32'h00001F1F;
        OFS_CHCTL: chctl_d = wb_dat_i & 32'h000000FF;
        OFS_CAR: car_d = wb_dat_i[CNT_W-1:0];
        OFS_CHCV: cv_d = wb_dat_i[CNT_W-1:0];
        default: ;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && !ack_q) begin
      case (effAdr)
        OFS_CTL0: rdat_d = ctl0_q;
        OFS_CTL1: rdat_d = ctl1_q;
        OFS_SMCFG: rdat_d = smcfg_q;
        OFS_STAT: rdat_d = stat_q;
        OFS_CHCTL: rdat_d = chctl_q;
        OFS_CNT: rdat_d = 32'(cnt_q);
        OFS_CAR: rdat_d = 32'(car_q);
        OFS_CHCV: rdat_d = 32'(cv_q);
        OFS_DMACFG: rdat_d = dmacfg_q;
        default: rdat_d = 32'h00000000; // Unmapped reads as zero
      endcase
    end
  end

  // Register stage for all state except the reset and input synchronisers
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      ctl0_q <= RST_VAL;
      ctl1_q <= RST_VAL;
      smcfg_q <= RST_VAL;
      dmacfg_q <= RST_VAL;
      chctl_q <= RST_VAL;
      stat_q <= RST_VAL;
      cnt_q <= '0;
      car_q <= '1;
      cv_q <= '0;
      ack_q <= 1'b0;
      rdat_q <= RST_VAL;
      filt_q <= 4'h0;
      prev_q <= 4'h0;
      fcnt0_q <= 4'h0;
      fcnt3_q <= 4'h0;
      divCnt_q <= 2'h0;
      psc_q <= 3'h0;
      pscOut_q <= 1'b0;
      trigSel_q <= 1'b0;
      alignStart_q <= 1'b0;
      ref_q <= 1'b0;
      trigger_output_line_q <= 1'b0;
      dmaSt_q <= DMA_IDLE;
      dmaIdx_q <= 5'h0;
    end else begin
      ctl0_q <= ctl0_d;
      ctl1_q <= ctl1_d;
      smcfg_q <= smcfg_d;
      dmacfg_q <= dmacfg_d;
      chctl_q <= chctl_d;
      stat_q <= stat_d;
      cnt_q <= cnt_d;
      car_q <= car_d;
      cv_q <= cv_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      filt_q <= filt_d;
      prev_q <= filt_q;
      fcnt0_q <= fcnt0_d;
      fcnt3_q <= fcnt3_d;
      divCnt_q <= divCnt_d;
      psc_q <= psc_d;
      pscOut_q <= pscOut_d;
      trigSel_q <= trigLevel;
      alignStart_q <= alignStart_d;
      ref_q <= ref_d;
      trigger_output_line_q <= trigger_output_line_d;
      dmaSt_q <= dmaSt_d;
      dmaIdx_q <= dmaIdx_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign triggerOutputLine = trigger_output_line_q;
  assign preOutputReference = ref_q;
endmodule
`default_nettype wire

// *** verif/peer_trigger_model.sv ***
/*
  Peer timer model: drives one internal trigger line high for a requested
  number of kernel cycles, as a master timer's trigger output would.
  Assumes the peer shares the kernel clock and reset of the timer.
*/
`default_nettype none
module peer_trigger_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic fire,
  input wire logic [7:0] pulseLen,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left;
  // Length latched at fire; a peer output is driven low, never floated
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      left <= 8'h00;
    end else if (fire) begin
      left <= pulseLen;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign line = (left != 8'h00);
endmodule
`default_nettype wire

// *** verif/timer_slave_sync_props.sv ***
/*
  Concurrent checks on the bus answer, trigger output and DMA request.
  Assumes a bind onto the top module and word writes seen on the bus.
*/
`default_nettype none
module timer_slave_sync_props
  import timer_slave_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic dmaReq,
  input wire logic triggerOutputLine,
  input wire logic preOutputReference
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] mmcQ;
  logic [2:0] mmcD;
  logic wrCtl0;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Master mode shadow, updated at the edge the write is taken
  always_comb begin
    mmcD = mmcQ;
    if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == OFS_CTL1) begin
      mmcD = wb_dat_i[MMC_LSB +: 3];
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mmcQ <= 3'h0;
    end else begin
      mmcQ <= mmcD;
    end
  end
  assign wrCtl0 = wb_ack_o && wb_we_i && wb_adr_i == OFS_CTL0;
  ack_follows_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h7C |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property ($rose(rstn) |-> !wb_ack_o && !dmaReq && !triggerOutputLine)
    else $error("outputs active out of reset");
  dma_drop_a: assert property ($rose(wb_cyc_i && wb_stb_i) && wb_adr_i == OFS_DMAWIN && dmaReq
    |-> ##[1:2] !dmaReq) else $error("dma request kept after access");
  trigger_output_line_pulse_a: assert property (mmcQ == MMC_UPDATE && triggerOutputLine |=> !triggerOutputLine)
    else $error("update trigger not a pulse");
  trigger_output_line_on_a: assert property (wrCtl0 && wb_dat_i[CEN_POS] && mmcQ == MMC_ENABLE
    |-> ##[1:3] triggerOutputLine) else $error("trigger output not following enable");
  trigger_output_line_off_a: assert property (wrCtl0 && !wb_dat_i[CEN_POS] && mmcQ == MMC_ENABLE
    |-> ##[1:3] !triggerOutputLine) else $error("trigger output not dropping");
  cover property (mmcQ == MMC_UPDATE && $rose(triggerOutputLine));
  cover property ($rose(dmaReq));
  cover property ($rose(preOutputReference));
endmodule
bind timer_slave_sync timer_slave_sync_props #(.CNT_W(CNT_W)) i_props (.mclk(mclk),
  .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .dmaReq(dmaReq), .triggerOutputLine(triggerOutputLine),
  .preOutputReference(preOutputReference));
`default_nettype wire

// *** verif/timer_slave_sync_test.sv ***
/*
  Self-checking bench: Wishbone register tasks, four peer trigger lines,
  DMA window accesses and debug inputs. Assumes 200 MHz kernel clock.
*/
`default_nettype none
module timer_slave_sync_test
  import timer_slave_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 20000;
  // Trigger table: code, peer line, filter, length, divider, expected
  localparam logic [3:0] T_CODE [8] = '{4'h0, 4'h1, 4'h4, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7};
  localparam int T_LINE [8] = '{3, 2, 1, 0, 0, 0, 0, 0};
  localparam logic [3:0] T_FLT [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h4, 4'h4, 4'h4};
  localparam logic [7:0] T_LEN [8] = '{8'h06, 8'h06, 8'h06, 8'h06, 8'h02, 8'h0C, 8'h0C, 8'h0C};
  localparam logic [1:0] T_DIV [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h3};
  localparam logic T_EXP [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] fire = 4'h0;
  logic [3:0] lines;
  logic [7:0] pulseLen = 8'h06;
  logic debugHalt = 1'b0;
  logic debugHoldBit = 1'b0;
  logic dmaEventReq = 1'b0;
  logic dmaReq;
  logic trigger_output_line;
  logic preRef;
  trig_in_s trigPins;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #2.5 mclk = ~mclk;
  assign trigPins = lines;
  peer_trigger_model i_peer[3:0] (.mclk(mclk), .rstn(rstn), .fire(fire), .pulseLen(pulseLen),
    .line(lines));
  timer_slave_sync #(.CNT_W(16)) i_dut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .trigPins(trigPins), .debugHalt(debugHalt),
    .debugHoldBit(debugHoldBit), .dmaEventReq(dmaEventReq), .dmaReq(dmaReq),
    .triggerOutputLine(trigger_output_line), .preOutputReference(preRef));
  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard; a timeout counts as a mismatch
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end
  // Classic cycle: request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s: expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic pulse(input int i);
    @(posedge mclk);
    fire[i] <= 1'b1;
    @(posedge mclk);
    fire <= 4'h0;
  endtask
  function automatic logic [31:0] smcfg(logic [2:0] m, logic [3:0] t, logic [3:0] f);
    return 32'(m) << SMC_LSB | 32'(t[2:0]) << TRIGGER_SOURCE_SELECT_LSB | 32'(t[3]) << TRGS3_POS
      | 32'(f) << EXT_TRIGGER_FILTER_CFG_LSB;
  endfunction
  function automatic int trgoPulses(int car, int span);
    return span / (car + 1);
  endfunction
  initial begin
    logic [31:0] a, b, c, d, q;
    logic [31:0] dv [3];
    int n, w;
    a = $urandom(19);
    tick(20);
    rstn <= 1'b1;
    tick(4);
    rd(OFS_CTL0, q);
    chk("ctl0 reset", RST_VAL, q);
    rd(OFS_SMCFG, q);
    chk("smcfg reset", RST_VAL, q);
    wr(8'h7C, 32'hFFFFFFFF);
    rd(8'h7C, q);
    chk("unmapped read", 32'h0, q);
    $display("test reset done");
    // Each trigger source and sample divider in event mode; odd rows align
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTL0, 32'(T_DIV[i]) << SAMPLE_CLOCK_DIVIDER_LSB);
      wr(OFS_STAT, 32'h0);
      wr(OFS_SMCFG, smcfg(SMC_EVENT, T_CODE[i], T_FLT[i]) | 32'(i[0]) << MSM_POS);
      pulseLen <= (T_FLT[i] == 4'h0) ? 8'(6 + $urandom_range(9)) : T_LEN[i];
      pulse(T_LINE[i]);
      tick(40);
      rd(OFS_CTL0, q);
      chk("event enable", T_EXP[i], q[CEN_POS]);
      rd(OFS_STAT, q);
      chk("trigger flag", T_EXP[i], q[TRIGGER_INTERRUPT_FLAG_POS]);
    end
    $display("test trigger select done");
    wr(OFS_SMCFG, smcfg(SMC_RESTART, TRG_INTERNAL_TRIGGER_LINE_0, 4'h0));
    wr(OFS_CTL0, 32'h1);
    tick(100);
    pulse(3);
    tick(8);
    rd(OFS_CNT, q);
    chk("restart count", 1'b1, q < 32'd16);
    wr(OFS_SMCFG, smcfg(SMC_PAUSE, TRG_INTERNAL_TRIGGER_LINE_1, 4'h0));
    wr(OFS_CTL0, 32'h1);
    tick(4);
    rd(OFS_CNT, a);
    tick(10);
    rd(OFS_CNT, b);
    chk("pause hold", a, b);
    pulseLen <= 8'h50;
    pulse(2);
    tick(8);
    rd(OFS_CNT, c);
    tick(10);
    rd(OFS_CNT, d);
    chk("pause resume", 1'b1, d > c && c >= b);
    tick(80);
    $display("test restart and pause done");
    // External clock mode 0: one count per trigger rising edge
    wr(OFS_SMCFG, smcfg(SMC_EXTCLK0, TRG_INTERNAL_TRIGGER_LINE_0, 4'h0));
    wr(OFS_CTL0, 32'h1);
    rd(OFS_CNT, a);
    n = 1 + $urandom_range(5);
    pulseLen <= 8'h02;
    repeat (n) begin
      pulse(3);
      tick(4);
    end
    tick(8);
    rd(OFS_CNT, b);
    chk("external clock count", a + 32'(n), b);
    $display("test external clock done");
    // Debug hold freezes only with the hold bit set
    wr(OFS_SMCFG, 32'h0);
    debugHalt <= 1'b1;
    debugHoldBit <= 1'b1;
    tick(2);
    rd(OFS_CNT, a);
    tick(10);
    rd(OFS_CNT, b);
    chk("debug freeze", a, b);
    debugHoldBit <= 1'b0;
    rd(OFS_CNT, c);
    tick(10);
    rd(OFS_CNT, d);
    chk("debug runs", 1'b1, d != c);
    debugHalt <= 1'b0;
    wr(OFS_CTL0, 32'h0);
    rd(OFS_CNT, a);
    tick(10);
    rd(OFS_CNT, b);
    chk("stop holds", 1'b1, a == b && a != 0);
    // Master output: update pulses, then enable level
    wr(OFS_CNT, 32'h0);
    wr(OFS_CAR, 32'd20);
    wr(OFS_CTL1, 32'(MMC_UPDATE) << MMC_LSB);
    wr(OFS_CTL0, 32'h1);
    n = 0;
    repeat (210) begin
      @(posedge mclk);
      n += int'(trigger_output_line === 1'b1);
    end
    chk("trigger_output_line pulses", 1'b1, n >= trgoPulses(20, 210) - 1 && n <= trgoPulses(20, 210) + 1);
    wr(OFS_CTL1, 32'(MMC_ENABLE) << MMC_LSB);
    wr(OFS_CTL0, 32'h0);
    tick(3);
    chk("trigger_output_line off", 1'b0, trigger_output_line);
    wr(OFS_CTL0, 32'h1);
    tick(3);
    chk("trigger_output_line on", 1'b1, trigger_output_line);
    wr(OFS_CTL1, 32'h0);
    $display("test master output done");
    // Single pulse started by a trigger, composite output mode
    wr(OFS_CTL0, 32'h0);
    wr(OFS_CHCTL, 32'(CHMS_OUTPUT) | 32'h1 << CPWM_POS);
    wr(OFS_CHCV, 32'd5);
    wr(OFS_CNT, 32'h0);
    wr(OFS_SMCFG, smcfg(SMC_EVENT, TRG_INTERNAL_TRIGGER_LINE_0, 4'h0));
    wr(OFS_CTL0, 32'h1 << SPM_POS);
    pulseLen <= 8'h06;
    chk("reference idle", 1'b0, preRef);
    pulse(3);
    tick(6);
    chk("reference forced", 1'b1, preRef);
    rd(OFS_CTL0, q);
    chk("pulse started", 1'b1, q[CEN_POS]);
    tick(40);
    rd(OFS_CTL0, q);
    chk("pulse ended", 1'b0, q[CEN_POS]);
    rd(OFS_CNT, q);
    chk("pulse cleared", 32'h0, q);
    $display("test single pulse done");
    // DMA burst of three window writes from the counter word onward
    wr(OFS_SMCFG, 32'h0);
    wr(OFS_CTL0, 32'h0);
    wr(OFS_DMACFG, 32'd2 << DMA_TRANSFER_COUNT_LSB | 32'(OFS_CNT >> 2) << DMA_START_ADDRESS_LSB);
    @(posedge mclk);
    dmaEventReq <= 1'b1;
    @(posedge mclk);
    dmaEventReq <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      dv[i] = 32'(16'($urandom)) | 32'h1;
      w = 0;
      while (dmaReq !== 1'b1 && w < 50) begin
        @(posedge mclk);
        w++;
      end
      chk("dma request", 1'b1, dmaReq);
      wr(OFS_DMAWIN, dv[i]);
    end
    tick(10);
    chk("dma burst length", 1'b0, dmaReq);
    rd(OFS_CNT, q);
    chk("dma first target", dv[0], q);
    rd(OFS_CAR, q);
    chk("dma third target", dv[2], q);
    $display("test dma done");
    final_report();
  end
endmodule
`default_nettype wire
